// ==== mifeu_params.svh ====
// Constants for the interrupt flag and enable unit: register offsets, field positions, reset values.
// Assumes inclusion by its bare name from package and modules.
`ifndef MIFEU_PARAMS_SVH
`define MIFEU_PARAMS_SVH
`define MIFEU_ADDR_W 3
`define MIFEU_OFS_BASE_CTRL 3'h0
`define MIFEU_OFS_SYS_EVENT 3'h1
`define MIFEU_OFS_TIMER_MATCH 3'h2
`define MIFEU_OFS_SERIAL_TB 3'h3
`define MIFEU_OFS_STATUS 3'h4
`define MIFEU_GIE_BIT 0
`define MIFEU_FLAG_LSB 4
`define MIFEU_SER_FLAG_LSB 4
`define MIFEU_SER_EN_LSB 0
`define MIFEU_RST_REG 8'h00
`define MIFEU_NSRC 10
`define MIFEU_VEC_W 12
`define MIFEU_VEC_BASE 12'h00C
`define MIFEU_VEC_STEP 12'h004
`endif

// ==== mifeu_pkg.sv ====
// Types shared by the interrupt flag and enable unit.
// Assumes mifeu_params.svh is on the include path.
`include "mifeu_params.svh"
package mifeu_pkg;
    typedef logic [`MIFEU_NSRC-1:0] mifeu_src_t;
    typedef logic [`MIFEU_VEC_W-1:0] mifeu_vec_t;
    typedef enum logic [1:0] {
        MIFEU_IDLE = 2'b00,
        MIFEU_PUSH = 2'b01,
        MIFEU_WAIT = 2'b10
    } mifeu_state_e;
endpackage : mifeu_pkg

// ==== mifeu_flag_cell.sv ====
// One interrupt request flag with its enable bit.
// Assumes a single clock; strobes are one cycle long.
`timescale 1ns/1ns
module mifeu_flag_cell (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic event_in,
    input wire logic flag_wr_in,
    input wire logic flag_wdata_in,
    input wire logic en_wr_in,
    input wire logic en_wdata_in,
    input wire logic serviced_in,
    output logic flag_out,
    output logic en_out
);
    logic flag_ff;
    logic en_ff;

    // Flag: event sets regardless of enable and wins over any clear
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flag_ff <= 1'b0;
        end else if (event_in) begin
            flag_ff <= 1'b1;
        end else if (serviced_in) begin
            flag_ff <= 1'b0;
        end else if (flag_wr_in) begin
            flag_ff <= flag_wdata_in;
        end
    end

    // Enable bit written by software
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            en_ff <= 1'b0;
        end else if (en_wr_in) begin
            en_ff <= en_wdata_in;
        end
    end

    assign flag_out = flag_ff;
    assign en_out = en_ff;
endmodule : mifeu_flag_cell

// ==== mifeu_top.sv ====
// Interrupt flag and enable unit: three control registers, global enable, priority select, vector request.
// Assumes the core pushes/pops its stack on request and reports stack full; registers on a plain strobe port.
// What this block does
// - First register upper nibble holds time-base-0, EEPROM, converter, low-voltage flags.
// - First register lower nibble holds the matching enables, one enables.
// - Timer register bits 7..4 hold std A, std P, per A, per P flags.
// - Timer register bits 3..0 hold enables in the same order.
// - Third register: serial flag bit 5, tb1 flag 4, serial enable 1, tb1 enable 0.
// - Third register bits 7..6 and 3..2 read zero.
// - Source events set their flag whatever the enable.
// - A flag causes a vector jump only while its enable is one.
// - Global enable low suppresses every interrupt.
// - On service push next address, load vector, fetch from there.
// - Return-from-interrupt pops the saved program counter.
// - Each source has its own distinct vector address.
// - Service clears the global enable automatically.
// - Requests during service still set and hold their flags.
// - No request acknowledged while the stack is full.
// - Among simultaneous enabled requests exactly one is serviced.
// - Any flag becoming set wakes the device from sleep or idle.
// - Service clears the serviced source's flag.
// - Global enable is bit 0 of the base register, resets to zero.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "mifeu_params.svh"
module mifeu_top #(
    parameter int NSRC = `MIFEU_NSRC
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [`MIFEU_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic [NSRC-1:0] src_event_in,
    input wire logic stack_full_in,
    input wire logic return_from_int_instr_in,
    input wire logic low_power_in,
    output logic int_req_out,
    output logic [`MIFEU_VEC_W-1:0] vector_out,
    output logic push_pc_out,
    output logic pop_pc_out,
    output logic wake_out
);
    // Source index order is priority order; index 0 sits at the lowest vector.
    // 0 lowvolt, 1 conv_done, 2 eeprom, 3 timebase0, 4 per cmp P, 5 per cmp A,
    // 6 std cmp P, 7 std cmp A, 8 timebase1, 9 serial xfer
    // Register map: offset 0 base control (global enable in bit 0),
    // 1 system events, 2 timer matches, 3 serial and time base 1,
    // 4 status (state in bits 5:4, any enabled request in bit 0)
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] ens;
    logic [NSRC-1:0] flag_wr;
    logic [NSRC-1:0] en_wr;
    logic [NSRC-1:0] flag_wd;
    logic [NSRC-1:0] en_wd;
    logic [NSRC-1:0] serviced;
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] grant;
    logic [3:0] grant_idx;
    logic any_pending;
    logic global_int_en_ff;
    logic [7:0] rdata_ff;
    logic int_req_ff;
    logic push_pc_ff;
    logic pop_pc_ff;
    logic wake_ff;
    logic [`MIFEU_VEC_W-1:0] vector_ff;
    logic [NSRC-1:0] flags_prev_ff;
    mifeu_pkg::mifeu_state_e state_ff;
    mifeu_pkg::mifeu_state_e nxt_state;
    logic wr_sys;
    logic wr_tmr;
    logic wr_ser;
    logic take;
    logic wr_base;
    logic svc_open;
    logic stack_room;
    logic [NSRC-1:0] flag_rise;
    logic [`MIFEU_VEC_W-1:0] grant_vec;
    logic [7:0] base_word;
    logic [7:0] sys_word;
    logic [7:0] tmr_word;
    logic [7:0] ser_word;
    logic [7:0] status_word;

    // Named register fields, one per flag and enable bit
    logic timebase0_req_flag;
    logic eeprom_req_flag;
    logic conv_done_req_flag;
    logic lowvolt_req_flag;
    logic timebase0_int_en;
    logic eeprom_int_en;
    logic conv_done_int_en;
    logic lowvolt_int_en;
    logic std_timer_cmpa_flag;
    logic std_timer_cmpp_flag;
    logic per_timer_cmpa_flag;
    logic per_timer_cmpp_flag;
    logic std_timer_cmpa_en;
    logic std_timer_cmpp_en;
    logic per_timer_cmpa_en;
    logic per_timer_cmpp_en;
    logic serial_xfer_req_flag;
    logic timebase1_req_flag;
    logic serial_xfer_int_en;
    logic timebase1_int_en;

    assign wr_sys = wr_in && (addr_in == `MIFEU_OFS_SYS_EVENT);
    assign wr_tmr = wr_in && (addr_in == `MIFEU_OFS_TIMER_MATCH);
    assign wr_ser = wr_in && (addr_in == `MIFEU_OFS_SERIAL_TB);
    assign wr_base = wr_in && (addr_in == `MIFEU_OFS_BASE_CTRL);

    // Write routing: register bit layout mapped onto source cells
    // Each register write rewrites all its flags and enables at once
    always_comb begin
        flag_wr = '0;
        en_wr = '0;
        flag_wd = '0;
        en_wd = '0;
        for (int i = 0; i < 4; i++) begin
            flag_wr[i] = wr_sys;
            en_wr[i] = wr_sys;
            flag_wd[i] = wdata_in[`MIFEU_FLAG_LSB + i];
            en_wd[i] = wdata_in[i];
            flag_wr[4 + i] = wr_tmr;
            en_wr[4 + i] = wr_tmr;
            flag_wd[4 + i] = wdata_in[`MIFEU_FLAG_LSB + i];
            en_wd[4 + i] = wdata_in[i];
        end
        for (int j = 0; j < 2; j++) begin
            flag_wr[8 + j] = wr_ser;
            en_wr[8 + j] = wr_ser;
            flag_wd[8 + j] = wdata_in[`MIFEU_SER_FLAG_LSB + j];
            en_wd[8 + j] = wdata_in[`MIFEU_SER_EN_LSB + j];
        end
    end

    // One flag cell per source
    // Event set beats service clear, which beats a software write
    for (genvar g = 0; g < NSRC; g++) begin : g_src
        mifeu_flag_cell u_cell (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .event_in(src_event_in[g]),
            .flag_wr_in(flag_wr[g]),
            .flag_wdata_in(flag_wd[g]),
            .en_wr_in(en_wr[g]),
            .en_wdata_in(en_wd[g]),
            .serviced_in(serviced[g]),
            .flag_out(flags[g]),
            .en_out(ens[g])
        );
    end

    // Field view of the first register
    assign timebase0_req_flag = flags[3];
    assign eeprom_req_flag = flags[2];
    assign conv_done_req_flag = flags[1];
    assign lowvolt_req_flag = flags[0];
    assign timebase0_int_en = ens[3];
    assign eeprom_int_en = ens[2];
    assign conv_done_int_en = ens[1];
    assign lowvolt_int_en = ens[0];

    // Field view of the timer-match register
    assign std_timer_cmpa_flag = flags[7];
    assign std_timer_cmpp_flag = flags[6];
    assign per_timer_cmpa_flag = flags[5];
    assign per_timer_cmpp_flag = flags[4];
    assign std_timer_cmpa_en = ens[7];
    assign std_timer_cmpp_en = ens[6];
    assign per_timer_cmpa_en = ens[5];
    assign per_timer_cmpp_en = ens[4];

    // Field view of the serial and time-base register
    assign serial_xfer_req_flag = flags[9];
    assign timebase1_req_flag = flags[8];
    assign serial_xfer_int_en = ens[9];
    assign timebase1_int_en = ens[8];

    // Gating by per-source enable, global enable and stack room
    assign pending = flags & ens;
    assign any_pending = |pending;
    assign svc_open = (state_ff == mifeu_pkg::MIFEU_IDLE) && global_int_en_ff;
    assign stack_room = !stack_full_in;
    // A full stack holds every request back until the core pops
    assign take = svc_open && any_pending && stack_room;

    // Fixed priority: lowest index, lowest vector, wins
    // Scanning from the top lets the lowest pending index overwrite the others
    always_comb begin
        grant = '0;
        grant_idx = 4'h0;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (pending[k]) begin
                grant = '0;
                grant[k] = 1'b1;
                grant_idx = 4'(k);
            end
        end
    end

    assign serviced = take ? grant : '0;

    // Vector of the granted source, one slot per source
    assign grant_vec = `MIFEU_VEC_BASE + `MIFEU_VEC_STEP * {8'h00, grant_idx};

    // Service sequencer: IDLE takes a request, PUSH covers the cycle in which the
    // core saves its counter, WAIT lets the stack-full level settle before the
    // next take is weighed
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mifeu_pkg::MIFEU_IDLE: begin
                if (take) begin
                    nxt_state = mifeu_pkg::MIFEU_PUSH;
                end
            end
            mifeu_pkg::MIFEU_PUSH: begin
                nxt_state = mifeu_pkg::MIFEU_WAIT;
            end
            mifeu_pkg::MIFEU_WAIT: begin
                nxt_state = mifeu_pkg::MIFEU_IDLE;
            end
            default: begin
                nxt_state = mifeu_pkg::MIFEU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_ff <= mifeu_pkg::MIFEU_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Global enable: software writes, service clears; service wins
    // Re-setting it inside a routine allows a nested take
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            global_int_en_ff <= 1'b0;
        end else if (take) begin
            global_int_en_ff <= 1'b0;
        end else if (wr_base) begin
            global_int_en_ff <= wdata_in[`MIFEU_GIE_BIT];
        end
    end

    // Core request: push pulse and per-source vector
    // Vector holds until the next service, so the core may read it late
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            push_pc_ff <= 1'b0;
            int_req_ff <= 1'b0;
            vector_ff <= '0;
        end else begin
            push_pc_ff <= take;
            int_req_ff <= take;
            if (take) begin
                vector_ff <= grant_vec;
            end
        end
    end

    // Return pops the saved counter
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            pop_pc_ff <= 1'b0;
        end else begin
            pop_pc_ff <= return_from_int_instr_in;
        end
    end

    // Flags that went from clear to set since the last cycle
    assign flag_rise = flags & ~flags_prev_ff;

    // Wake on any flag rising while in low power; pre-set flags do not wake
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flags_prev_ff <= '0;
            wake_ff <= 1'b0;
        end else begin
            flags_prev_ff <= flags;
            wake_ff <= low_power_in && (|flag_rise);
        end
    end

    // Read words assembled from the named fields
    assign base_word = {7'h00, global_int_en_ff};
    assign sys_word = {timebase0_req_flag, eeprom_req_flag, conv_done_req_flag, lowvolt_req_flag,
        timebase0_int_en, eeprom_int_en, conv_done_int_en, lowvolt_int_en};
    assign tmr_word = {std_timer_cmpa_flag, std_timer_cmpp_flag, per_timer_cmpa_flag, per_timer_cmpp_flag,
        std_timer_cmpa_en, std_timer_cmpp_en, per_timer_cmpa_en, per_timer_cmpp_en};
    assign ser_word = {2'h0, serial_xfer_req_flag, timebase1_req_flag,
        2'h0, serial_xfer_int_en, timebase1_int_en};
    assign status_word = {2'h0, state_ff, 3'h0, any_pending};

    // Read data, one cycle after the strobe
    // Reads have no side effect on flags; the port idles at zero
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata_ff <= `MIFEU_RST_REG;
        end else if (rd_in) begin
            case (addr_in)
                `MIFEU_OFS_BASE_CTRL: begin
                    rdata_ff <= base_word;
                end
                `MIFEU_OFS_SYS_EVENT: begin
                    rdata_ff <= sys_word;
                end
                `MIFEU_OFS_TIMER_MATCH: begin
                    rdata_ff <= tmr_word;
                end
                `MIFEU_OFS_SERIAL_TB: begin
                    rdata_ff <= ser_word;
                end
                `MIFEU_OFS_STATUS: begin
                    rdata_ff <= status_word;
                end
                // Unmapped offsets read as zero
                default: begin
                    rdata_ff <= 8'h00;
                end
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign rdata_out = rdata_ff;
    assign int_req_out = int_req_ff;
    assign push_pc_out = push_pc_ff;
    assign pop_pc_out = pop_pc_ff;
    assign vector_out = vector_ff;
    assign wake_out = wake_ff;
endmodule : mifeu_top

// ==== mifeu_properties.sv ====
// Port checker for the interrupt flag and enable unit.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "mifeu_params.svh"
module mifeu_props #(
    parameter int NSRC = `MIFEU_NSRC
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [`MIFEU_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic stack_full_in,
    input wire logic return_from_int_instr_in,
    input wire logic low_power_in,
    input wire logic int_req_out,
    input wire logic [`MIFEU_VEC_W-1:0] vector_out,
    input wire logic push_pc_out,
    input wire logic pop_pc_out,
    input wire logic wake_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // Software writes that turn the global enable on or off
    wire gie_on = wr_in && addr_in == `MIFEU_OFS_BASE_CTRL && wdata_in[0];
    wire gie_off = wr_in && addr_in == `MIFEU_OFS_BASE_CTRL && !wdata_in[0];
    sequence s_take;
        int_req_out && !gie_on ##1 !gie_on [*3];
    endsequence
    property p_push; int_req_out |-> push_pc_out ##1 !push_pc_out; endproperty
    property p_full; int_req_out |-> !$past(stack_full_in); endproperty
    property p_gap; int_req_out |=> !int_req_out [*2]; endproperty
    property p_pop; return_from_int_instr_in |=> pop_pc_out; endproperty
    property p_vec;
        int_req_out |-> vector_out >= `MIFEU_VEC_BASE && vector_out[1:0] == 2'h0
            && vector_out < `MIFEU_VEC_BASE + 4 * NSRC;
    endproperty
    property p_unimp;
        rd_in && addr_in == `MIFEU_OFS_SERIAL_TB |=> rdata_out[7:6] == 2'h0 && rdata_out[3:2] == 2'h0;
    endproperty
    property p_gie_off; gie_off |=> ##1 !int_req_out; endproperty
    property p_wake; wake_out |-> $past(low_power_in); endproperty
    property p_one_take; s_take |=> !int_req_out; endproperty
    a_push: assert property (p_push) else $error("push missing");
    a_full: assert property (p_full) else $error("taken while full");
    a_gap: assert property (p_gap) else $error("takes too close");
    a_pop: assert property (p_pop) else $error("pop missing");
    a_vec: assert property (p_vec) else $error("bad vector");
    a_unimp: assert property (p_unimp) else $error("unused bits set");
    a_gie_off: assert property (p_gie_off) else $error("taken with enable off");
    a_wake: assert property (p_wake) else $error("wake while awake");
    a_one_take: assert property (p_one_take) else $error("nested take");
endmodule : mifeu_props
bind mifeu_top mifeu_props #(.NSRC(NSRC)) u_props (.clock_in(clock_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .stack_full_in(stack_full_in), .return_from_int_instr_in(return_from_int_instr_in),
    .low_power_in(low_power_in), .int_req_out(int_req_out), .vector_out(vector_out),
    .push_pc_out(push_pc_out), .pop_pc_out(pop_pc_out), .wake_out(wake_out));

// ==== mifeu_core_model.sv ====
// Behavioural core: program counter and a small hardware stack.
// Assumes one-cycle push and pop pulses from the interrupt unit.
`timescale 1ns/1ns
module mifeu_core_model #(
    parameter int DEPTH = 2
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [11:0] vec_in,
    output logic full_out,
    output logic [11:0] pc_out
);
    logic [11:0] stack_ff [DEPTH];
    int sp_ff;
    // Push saves the pc and jumps to the vector, pop restores it
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sp_ff <= 0;
            pc_out <= 12'h100;
        end else if (push_in && sp_ff < DEPTH) begin
            stack_ff[sp_ff] <= pc_out;
            sp_ff <= sp_ff + 1;
            pc_out <= vec_in;
        end else if (pop_in && sp_ff > 0) begin
            sp_ff <= sp_ff - 1;
            pc_out <= stack_ff[sp_ff-1];
        end
    end
    assign full_out = (sp_ff == DEPTH);
endmodule : mifeu_core_model

// ==== mifeu_top_tb_top.sv ====
// Self-checking bench for the interrupt unit with a core model.
// Assumes a 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "mifeu_params.svh"
module mifeu_top_tb_top;
    logic clock_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic ret_in = 1'b0, low_in = 1'b0, full, req, push, pop, wake;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00, rdata, d;
    logic [9:0] src_in = 10'h000;
    logic [11:0] vec, pc, pc0;
    int fails = 0, n_checks = 0;
    bit hit;
    mifeu_top uut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata), .src_event_in(src_in), .stack_full_in(full),
        .return_from_int_instr_in(ret_in), .low_power_in(low_in), .int_req_out(req),
        .vector_out(vec), .push_pc_out(push), .pop_pc_out(pop), .wake_out(wake));
    mifeu_core_model core (.clock_in(clock_in), .rst_in(rst_in), .push_in(push), .pop_in(pop),
        .vec_in(vec), .full_out(full), .pc_out(pc));
    // Free-running clock
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    task automatic give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [2:0] areg(input int i);
        return i < 4 ? 3'h1 : (i < 8 ? 3'h2 : 3'h3);
    endfunction : areg
    function automatic int boff(input int i);
        return i < 8 ? i % 4 : i - 8;
    endfunction : boff
    function automatic logic [11:0] vexp(input int i);
        return `MIFEU_VEC_BASE + 12'(4 * i);
    endfunction : vexp
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(negedge clock_in);
        d = rdata;
    endtask : rd
    task automatic ev(input logic [9:0] m);
        @(posedge clock_in);
        src_in <= m;
        @(posedge clock_in);
        src_in <= 10'h000;
    endtask : ev
    task automatic ret_pulse();
        @(posedge clock_in);
        ret_in <= 1'b1;
        @(posedge clock_in);
        ret_in <= 1'b0;
        @(negedge clock_in);
        chk("pop", 1'b1, pop);
        @(negedge clock_in);
    endtask : ret_pulse
    // Watches the request (w=0) or wake (w=1) output for n cycles
    task automatic watch(input bit w, input int n, input bit e);
        hit = 1'b0;
        for (int k = 0; k < n && !hit; k++) begin
            @(negedge clock_in);
            hit = (w ? wake : req) === 1'b1;
        end
        chk(w ? "wake" : "req", e, hit);
        if (e && !hit) give_verdict();
    endtask : watch
    task automatic t_regs();
        int al[4] = '{1, 2, 3, 5};
        logic [7:0] ex[4] = '{8'hFF, 8'hFF, 8'h33, 8'h00};
        for (int a = 0; a < 6; a++) begin
            rd(3'(a));
            chk("reset", 8'h00, d);
        end
        for (int j = 0; j < 4; j++) begin
            wr(3'(al[j]), 8'hFF);
            rd(3'(al[j]));
            chk("rw", ex[j], d);
            wr(3'(al[j]), 8'h00);
        end
    endtask : t_regs
    task automatic t_events();
        wr(3'h0, 8'h01);
        for (int i = 0; i < 10; i++) begin
            ev(10'h001 << i);
            rd(areg(i));
            chk("flag", 1'b1, d[4+boff(i)]);
        end
        watch(0, 4, 0);
        for (int a = 0; a < 4; a++) wr(3'(a), 8'h00);
    endtask : t_events
    task automatic t_one(input int i);
        wr(areg(i), 8'h01 << boff(i));
        wr(3'h0, 8'h01);
        pc0 = pc;
        ev(10'h001 << i);
        watch(0, 10, 1);
        chk("vector", vexp(i), vec);
        chk("push", 1'b1, push);
        @(negedge clock_in);
        chk("pc", vexp(i), pc);
        rd(3'h0);
        chk("gie", 1'b0, d[0]);
        rd(areg(i));
        chk("served", 1'b0, d[4+boff(i)]);
        ret_pulse();
        chk("pc back", pc0, pc);
        wr(areg(i), 8'h00);
    endtask : t_one
    task automatic t_prio();
        ev(10'h3FF);
        for (int a = 1; a < 4; a++) wr(3'(a), 8'hFF);
        watch(0, 5, 0);
        for (int j = 0; j < 2; j++) begin
            wr(3'h0, 8'h01);
            watch(0, 10, 1);
            chk("prio", vexp(j), vec);
        end
        wr(3'h0, 8'h01);
        watch(0, 8, 0);
        rd(3'h4);
        chk("status", 8'h01, d);
        ret_pulse();
        watch(0, 10, 1);
        chk("after pop", vexp(2), vec);
        ret_pulse();
        ret_pulse();
        for (int a = 0; a < 4; a++) wr(3'(a), 8'h00);
    endtask : t_prio
    task automatic t_wake();
        @(posedge clock_in);
        low_in <= 1'b1;
        ev(10'h008);
        watch(1, 4, 1);
        ev(10'h008);
        watch(1, 4, 0);
        @(posedge clock_in);
        low_in <= 1'b0;
    endtask : t_wake
    // Main sequence
    initial begin
        repeat (3) @(posedge clock_in);
        rst_in <= 1'b0;
        t_regs();
        t_events();
        for (int i = 0; i < 10; i++) t_one(i);
        t_prio();
        t_wake();
        give_verdict();
    end
endmodule : mifeu_top_tb_top
